//--- bench/lfu_fabric_model.sv
// routing fabric stand-in that shapes cell strobe pulses
`timescale 1ns/1ps

module lfu_fabric_model
  import lfu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fire,
  output logic cellStrobe
);
  // ----
  // strobe shaping
  // ----
  logic gap;

  // one high cycle, then two forced low cycles so every rise is a fresh edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cellStrobe <= 1'b0;
      gap <= 1'b0;
    end else begin
      cellStrobe <= fire && !cellStrobe && !gap;
      gap <= cellStrobe;
    end
  end
endmodule

//--- bench/test_lfu_function_unit.sv
// self-checking bench of the logic cell function unit
`timescale 1ns/1ps
`include "lfu_regs.svh"

module test_lfu_function_unit
  import lfu_pkg::*;
();
  // ----
  // signals
  // ----
  logic clk, rst_n, gsrN, specialIn, clockGate, localSr, carryIn, regWrite, regRead, fire;
  logic [4:0] upperIn, lowerIn, resultBus;
  logic [3:0] directBus;
  logic [7:0] regAddr;
  logic [31:0] regWriteData, regReadData;
  logic cellStrobe, carryOut;
  logic [63:0] tbl;
  int errors, samplesChecked, cycles;

  lfu_function_unit lfu_function_unit_inst (.clk(clk), .rst_n(rst_n), .globalSetResetN(gsrN),
    .upperIn(upperIn), .lowerIn(lowerIn), .directStoreBus(directBus), .specialInput(specialIn),
    .cellStrobe(cellStrobe), .clockGate(clockGate), .localSetReset(localSr), .carryIn(carryIn),
    .resultBus(resultBus), .carryOut(carryOut), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData));

  lfu_fabric_model lfu_fabric_model_inst (.clk(clk), .rst_n(rst_n), .fire(fire), .cellStrobe(cellStrobe));

  // ----
  // helpers
  // ----
  task automatic testDone();
    $display("checked %0d errors %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // strobes are dropped a cycle later, so the next call never lands in the same step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regReadData;
  endtask

  // one strobe through the fabric, then enough cycles for the load to show
  task automatic pulse();
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // expected table lines for dual four-input, five-input and the two combos
  function automatic logic [3:0] lines(input logic [63:0] t, input logic [6:0] m, input logic [4:0] a,
      input logic [4:0] b, input logic c);
    logic hu, hl;
    hu = t[32 + a];
    hl = t[b];
    if (m == 7'h00)
      return {t[48 + {a[3:1], a[4]}], t[32 + a[3:0]], t[16 + {b[3:1], b[4]}], t[b[3:0]]};
    if (m == 7'h05)
      return {hu, 2'b00, hl};
    return {hu, ~(hu & hl & c), (m == 7'h25) ? (c ? hu : hl) : (hu ^ hl ^ c), hl};
  endfunction

  // ----
  // clock and watchdog
  // ----
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // the run needs a few hundred cycles; far beyond that means a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      testDone();
    end
  end

  // ----
  // main sequence
  // ----
  initial begin
    logic [31:0] d;
    logic [6:0] m;
    logic [4:0] s;
    logic [3:0] v;
    logic en;
    {rst_n, specialIn, clockGate, localSr, carryIn, regWrite, regRead, fire} = '0;
    {upperIn, lowerIn, directBus, regAddr, regWriteData} = '0;
    gsrN = 1'b1;
    void'($urandom(4857));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, the unmapped slot 0x14 among them
    for (int i = 0; i < 6; i++) begin
      rd(8'(i * 4), d);
      chk(d, 32'h0);
    end
    @(posedge clk);
    #1 chk({carryOut, resultBus}, 32'h0);
    chk(regReadData, 32'h0);
    // combinational modes with bypass, special input randomly enabled
    for (int i = 0; i < 32; i++) begin
      m = (i % 4 == 0) ? 7'h00 : (i % 4 == 1) ? 7'h05 : (i % 4 == 2) ? 7'h25 : 7'h45;
      tbl = {$urandom, $urandom};
      en = 1'($urandom);
      wr(`LFU_OFS_TABLE_LO, tbl[31:0]);
      wr(`LFU_OFS_TABLE_HI, tbl[63:32]);
      wr(`LFU_OFS_MODE, 32'(m));
      wr(`LFU_OFS_CTRL, 32'h000f0000 | (32'(en) << 6));
      @(posedge clk);
      upperIn <= 5'($urandom);
      lowerIn <= 5'($urandom);
      specialIn <= 1'($urandom);
      @(posedge clk);
      #1 chk(resultBus, {1'b0, lines(tbl, m, upperIn, lowerIn, specialIn & en)});
    end
    // ripple adder, all-ones plus carry first
    wr(`LFU_OFS_MODE, 32'h10);
    wr(`LFU_OFS_CTRL, 32'h000f0000);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      upperIn <= (i == 0) ? 5'h0f : 5'($urandom);
      lowerIn <= (i == 0) ? 5'h0f : 5'($urandom);
      carryIn <= (i == 0) ? 1'b1 : 1'($urandom);
      @(posedge clk);
      #1 s = 5'(upperIn[3:0]) + 5'(lowerIn[3:0]) + 5'(carryIn);
      chk({carryOut, resultBus}, {s[4], s[4], s[3:0]});
    end
    // both halves as 16 x 2 memory: the direct bus is written at the strobe edge
    wr(`LFU_OFS_MODE, 32'h0a);
    wr(`LFU_OFS_CTRL, 32'h000f0000);
    @(posedge clk);
    upperIn <= {1'b1, 4'($urandom)};
    lowerIn <= {1'b1, 4'($urandom)};
    directBus <= 4'($urandom);
    pulse();
    tbl[32 + upperIn[3:0]] = directBus[2];
    tbl[48 + upperIn[3:0]] = directBus[3];
    tbl[lowerIn[3:0]] = directBus[0];
    tbl[16 + lowerIn[3:0]] = directBus[1];
    chk(resultBus, {1'b0, directBus});
    rd(`LFU_OFS_TABLE_LO, d);
    chk(d, tbl[31:0]);
    rd(`LFU_OFS_TABLE_HI, d);
    chk(d, tbl[63:32]);
    // storage fed from the table lines
    wr(`LFU_OFS_MODE, 32'h0);
    wr(`LFU_OFS_CTRL, 32'h0);
    pulse();
    chk(resultBus, {1'b0, lines(tbl, 7'h00, upperIn, lowerIn, 1'b0)});
    // storage fed from the direct bus, gate disabled
    wr(`LFU_OFS_CTRL, 32'h00f00);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      directBus <= 4'($urandom);
      pulse();
      chk(resultBus, {1'b0, directBus});
    end
    // gate enabled: inactive gate blocks the load, active gate lets it through
    v = directBus;
    wr(`LFU_OFS_CTRL, 32'h00f02);
    @(posedge clk);
    clockGate <= 1'b0;
    directBus <= ~v;
    pulse();
    chk(resultBus, {1'b0, v});
    @(posedge clk);
    clockGate <= 1'b1;
    pulse();
    chk(resultBus, {1'b0, ~v});
    rd(`LFU_OFS_STATUS, d);
    chk(d[3:0], {~v});
    // synchronous local set/reset waits for a strobe
    wr(`LFU_OFS_CTRL, {16'h0, v, 12'hf08});
    @(posedge clk);
    localSr <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(resultBus[3:0], {~v});
    pulse();
    chk(resultBus[3:0], v);
    @(posedge clk);
    localSr <= 1'b0;
    // asynchronous local set/reset acts before any edge and beats a strobe
    wr(`LFU_OFS_CTRL, {16'h0, ~v, 12'hf28});
    @(posedge clk);
    localSr <= 1'b1;
    directBus <= v;
    #1 chk(resultBus[3:0], {~v});
    pulse();
    chk(resultBus[3:0], {~v});
    @(posedge clk);
    localSr <= 1'b0;
    // global set/reset is asynchronous and the forced value stays after release
    wr(`LFU_OFS_CTRL, {16'h0, v, 12'hf00});
    @(posedge clk);
    gsrN <= 1'b0;
    #1 chk(resultBus[3:0], v);
    @(posedge clk);
    gsrN <= 1'b1;
    @(posedge clk);
    #1 chk(resultBus[3:0], v);
    testDone();
  end
endmodule

//--- rtl/lfu_function_unit.sv
// function unit of a programmable logic cell: 64-bit table, special gates, four storage elements
`timescale 1ns/1ps
//
// How it works
// R01: nineteen cell inputs and six cell outputs, roles set by the mode.
// R02: two five-bit table buses, four-bit direct bus, special, strobe, gate, set/reset, carry.
// R03: five-bit result bus and a carry output toward the next cell.
// R04: in memory mode the direct bus is the table write data.
// R05: each storage element loads either its table output or the direct bus.
// R06: table outputs may bypass storage to reach the result bus.
// R07: strobe, gate, local set/reset shared by all four elements, each polarity selectable.
// R08: active gate blocks loading; gate can be disabled so every strobe loads. The code loads only while the gate is active; an inactive gate blocks.
// R09: local set/reset sync or async, off by default; each element sets or resets.
// R10: active-low global set/reset reaches every element, always asynchronous.
// R11: asynchronous set/reset overrides clocked loading.
// R12: special input feeds the special gates, disabled by default.
// R13: table is two 32-bit halves of two quarters each, quarters zero to three.
// R14: upper half holds quarters two and three, lower half zero and one.
// R15: ripple mode removes the table from use; otherwise halves choose modes independently.
// R16: dual four-input halves share three inputs, bits one to three of their bus.
// R17: five-input halves drive lines zero and three, stored or direct.
// R18: mux combo: line one picks upper result when special high, else lower.
// R19: xor combo: line one is xor of both half results and special input.
// R20: both combos: line two is nand of both results and special input.
// R21: mux and xor combos exclusive, both need two five-input halves.
// R22: configuration static during operation; table loaded before use.

`include "lfu_regs.svh"

module lfu_function_unit
  import lfu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic globalSetResetN,
  input wire logic [4:0] upperIn, // R01 R02
  input wire logic [4:0] lowerIn, // R01 R02
  input wire logic [3:0] directStoreBus, // R02
  input wire logic specialInput,
  input wire logic cellStrobe,
  input wire logic clockGate,
  input wire logic localSetReset,
  input wire logic carryIn,
  output logic [4:0] resultBus,
  output logic carryOut,
  input wire logic [`LFU_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regReadData
);

  // ----------------------------------------------------------------
  // configuration and table storage
  // ----------------------------------------------------------------

  logic [`LFU_MODE_W-1:0] modeReg;
  logic [`LFU_CTRL_W-1:0] ctrlReg;
  logic [63:0] tableBits;
  logic [31:0] next_readData;

  // mode and control are only meant to change while the cell is idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      modeReg <= `LFU_MODE_RESET;
      ctrlReg <= `LFU_CTRL_RESET; // R09 R12
    end else if (regWrite) begin
      if (regAddr == `LFU_OFS_MODE) begin
        modeReg <= regWriteData[`LFU_MODE_W-1:0]; // R22
      end
      if (regAddr == `LFU_OFS_CTRL) begin
        ctrlReg <= regWriteData[`LFU_CTRL_W-1:0]; // R22
      end
    end
  end

  // ----------------------------------------------------------------
  // decoded configuration
  // ----------------------------------------------------------------

  lfu_half_mode_t upperMode;
  lfu_half_mode_t lowerMode;
  lfu_special_t specialMode;
  logic rippleMode;
  logic strobeEff;
  logic strobePrev;
  logic strobeEdge;
  logic gateOn;
  logic gateActive;
  logic lsrActive;
  logic lsrAsync;
  logic specialEff;
  logic [3:0] directSel;
  logic [3:0] setValue;
  logic [3:0] bypass;

  assign upperMode = lfu_half_mode_t'(modeReg[`LFU_MODE_UPPER_LSB +: 2]);
  assign lowerMode = lfu_half_mode_t'(modeReg[`LFU_MODE_LOWER_LSB +: 2]);
  assign rippleMode = modeReg[`LFU_MODE_RIPPLE_BIT];
  assign directSel = ctrlReg[`LFU_CTRL_DIRECT_LSB +: 4];
  assign setValue = ctrlReg[`LFU_CTRL_SETVAL_LSB +: 4];
  assign bypass = ctrlReg[`LFU_CTRL_BYPASS_LSB +: 4];

  // a combo is only honoured with both halves five-input; illegal codes fall back to none
  always_comb begin
    specialMode = LFU_SPECIAL_NONE;
    if (!rippleMode && upperMode == LFU_FIVE_IN && lowerMode == LFU_FIVE_IN) begin // R21
      unique case (modeReg[`LFU_MODE_SPECIAL_LSB +: 2])
        2'b01: specialMode = LFU_FIVE_IN_MUX_COMBO;
        2'b10: specialMode = LFU_FIVE_IN_XOR_COMBO;
        default: specialMode = LFU_SPECIAL_NONE;
      endcase
    end
  end

  // control inputs with their selected polarity
  assign strobeEff = cellStrobe ^ ctrlReg[`LFU_CTRL_STROBE_INV]; // R07
  assign gateOn = ctrlReg[`LFU_CTRL_GATE_EN];
  assign gateActive = gateOn ? (clockGate ^ ctrlReg[`LFU_CTRL_GATE_INV]) : 1'b1; // R07 R08
  assign lsrActive = ctrlReg[`LFU_CTRL_LSR_EN] & (localSetReset ^ ctrlReg[`LFU_CTRL_LSR_INV]); // R07 R09
  assign lsrAsync = ctrlReg[`LFU_CTRL_LSR_ASYNC];
  assign specialEff = ctrlReg[`LFU_CTRL_SPECIAL_EN] & (specialInput ^ ctrlReg[`LFU_CTRL_SPECIAL_INV]); // R12

  // cell strobe is sampled on clk, so a rising edge shows as a one-cycle pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strobePrev <= 1'b0;
    end else begin
      strobePrev <= strobeEff;
    end
  end

  assign strobeEdge = strobeEff & ~strobePrev; // R07

  // ----------------------------------------------------------------
  // table contents: software load and memory-mode writes
  // ----------------------------------------------------------------

  logic memWriteUpper;
  logic memWriteLower;

  assign memWriteUpper = !rippleMode && upperMode == LFU_MEMORY && upperIn[4] && strobeEdge && gateActive;
  assign memWriteLower = !rippleMode && lowerMode == LFU_MEMORY && lowerIn[4] && strobeEdge && gateActive;

  // quarter k sits at bits 16k+15 down to 16k
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tableBits <= `LFU_TABLE_RESET;
    end else begin
      if (regWrite && regAddr == `LFU_OFS_TABLE_LO) begin
        tableBits[31:0] <= regWriteData; // R22
      end
      if (regWrite && regAddr == `LFU_OFS_TABLE_HI) begin
        tableBits[63:32] <= regWriteData; // R22
      end
      if (memWriteUpper) begin
        tableBits[32 + {2'b00, upperIn[3:0]}] <= directStoreBus[2]; // R04 R14
        tableBits[48 + {2'b00, upperIn[3:0]}] <= directStoreBus[3]; // R04 R14
      end
      if (memWriteLower) begin
        tableBits[{2'b00, lowerIn[3:0]}] <= directStoreBus[0]; // R04 R14
        tableBits[16 + {2'b00, lowerIn[3:0]}] <= directStoreBus[1]; // R04 R14
      end
    end
  end

  // ----------------------------------------------------------------
  // table read paths
  // ----------------------------------------------------------------

  logic [15:0] quarter0;
  logic [15:0] quarter1;
  logic [15:0] quarter2;
  logic [15:0] quarter3;
  logic [31:0] upperHalf;
  logic [31:0] lowerHalf;
  logic [4:0] rippleSum;
  logic [3:0] tableF;
  logic [3:0] halfF;

  assign quarter0 = tableBits[15:0]; // R13
  assign quarter1 = tableBits[31:16]; // R13
  assign quarter2 = tableBits[47:32]; // R13
  assign quarter3 = tableBits[63:48]; // R13
  assign upperHalf = {quarter3, quarter2}; // R14
  assign lowerHalf = {quarter1, quarter0}; // R14

  // ripple uses plain carry logic; the table is not consulted
  assign rippleSum = {1'b0, upperIn[3:0]} + {1'b0, lowerIn[3:0]} + {4'h0, carryIn};

  // per-half outputs before the special gates
  always_comb begin
    halfF = 4'h0;
    unique case (upperMode)
      LFU_DUAL_FOUR_IN: begin
        halfF[2] = quarter2[upperIn[3:0]]; // R16
        halfF[3] = quarter3[{upperIn[3:1], upperIn[4]}]; // R16
      end
      LFU_FIVE_IN: begin
        halfF[3] = upperHalf[upperIn]; // R17
      end
      LFU_MEMORY: begin
        halfF[2] = quarter2[upperIn[3:0]];
        halfF[3] = quarter3[upperIn[3:0]];
      end
      default: begin
        halfF[3:2] = 2'b00;
      end
    endcase
    unique case (lowerMode)
      LFU_DUAL_FOUR_IN: begin
        halfF[0] = quarter0[lowerIn[3:0]]; // R16
        halfF[1] = quarter1[{lowerIn[3:1], lowerIn[4]}]; // R16
      end
      LFU_FIVE_IN: begin
        halfF[0] = lowerHalf[lowerIn]; // R17
      end
      LFU_MEMORY: begin
        halfF[0] = quarter0[lowerIn[3:0]];
        halfF[1] = quarter1[lowerIn[3:0]];
      end
      default: begin
        halfF[1:0] = 2'b00;
      end
    endcase
  end

  // special gates take lines one and two; ripple overrides everything
  always_comb begin
    tableF = halfF;
    if (rippleMode) begin
      tableF = rippleSum[3:0]; // R15
    end else begin
      unique case (specialMode)
        LFU_SPECIAL_NONE: begin
          tableF = halfF;
        end
        LFU_FIVE_IN_MUX_COMBO: begin
          tableF[1] = specialEff ? halfF[3] : halfF[0]; // R18
          tableF[2] = ~(halfF[3] & halfF[0] & specialEff); // R20
        end
        LFU_FIVE_IN_XOR_COMBO: begin
          tableF[1] = halfF[3] ^ halfF[0] ^ specialEff; // R19
          tableF[2] = ~(halfF[3] & halfF[0] & specialEff); // R20
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // storage elements
  // ----------------------------------------------------------------

  logic asyncForce;
  logic syncForce;
  logic capture;
  logic [3:0] storeIn;
  logic [3:0] storeQ;

  assign asyncForce = !globalSetResetN || (lsrActive && lsrAsync); // R10 R11
  assign syncForce = lsrActive && !lsrAsync && strobeEdge && gateActive; // R09
  assign capture = strobeEdge && gateActive; // R08
  assign storeIn = (directSel & directStoreBus) | (~directSel & tableF); // R05

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gStore
      lfu_store_cell uCell (
        .clk(clk),
        .rst_n(rst_n),
        .dataIn(storeIn[gi]),
        .capture(capture),
        .syncForce(syncForce),
        .asyncForce(asyncForce),
        .setValue(setValue[gi]),
        .q(storeQ[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // cell outputs
  // ----------------------------------------------------------------

  // combinational paths skip the storage delay when bypass is chosen
  assign resultBus[3:0] = (bypass & tableF) | (~bypass & storeQ); // R06 R17
  assign resultBus[4] = rippleMode ? rippleSum[4] : 1'b0; // R03
  assign carryOut = rippleMode ? rippleSum[4] : 1'b0; // R03

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------

  always_comb begin
    next_readData = 32'h00000000;
    if (regRead) begin
      if (regAddr == `LFU_OFS_MODE) begin
        next_readData[`LFU_MODE_W-1:0] = modeReg;
      end else if (regAddr == `LFU_OFS_CTRL) begin
        next_readData[`LFU_CTRL_W-1:0] = ctrlReg;
      end else if (regAddr == `LFU_OFS_TABLE_LO) begin
        next_readData = tableBits[31:0];
      end else if (regAddr == `LFU_OFS_TABLE_HI) begin
        next_readData = tableBits[63:32];
      end else if (regAddr == `LFU_OFS_STATUS) begin
        next_readData[`LFU_STAT_STORE_LSB +: 4] = storeQ;
        next_readData[`LFU_STAT_RESULT_LSB +: 5] = resultBus;
        next_readData[`LFU_STAT_CARRY_BIT] = carryOut;
        next_readData[`LFU_STAT_TABLE_LSB +: 4] = tableF;
      end
    end
  end

  // data stand only in the cycle after the read; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regReadData <= 32'h00000000;
    end else begin
      regReadData <= next_readData;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------

  default clocking cbMain @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seqLoadDirect0;
    capture && !asyncForce && !syncForce && directSel[0] && !bypass[0];
  endsequence

  sequence seqQuiet;
    !asyncForce && !syncForce && !capture;
  endsequence

  AST_MUX_LINE: assert property (specialMode == LFU_FIVE_IN_MUX_COMBO |-> tableF[1] == (specialEff ? halfF[3] : halfF[0])) // R18
    else $error("mux combo line one wrong");

  AST_XOR_LINE: assert property (specialMode == LFU_FIVE_IN_XOR_COMBO |-> tableF[1] == (halfF[3] ^ halfF[0] ^ specialEff)) // R19
    else $error("xor combo line one wrong");

  AST_NAND_LINE: assert property (specialMode != LFU_SPECIAL_NONE |-> tableF[2] == !(tableF[3] && tableF[0] && specialEff)) // R20
    else $error("nand line wrong");

  AST_COMBO_NEEDS_FIVE: assert property (specialMode != LFU_SPECIAL_NONE |-> upperMode == LFU_FIVE_IN && lowerMode == LFU_FIVE_IN) // R21
    else $error("combo active without two five-input halves");

  AST_RIPPLE_CARRY: assert property (rippleMode |-> {carryOut, tableF} == upperIn[3:0] + lowerIn[3:0] + carryIn) // R15
    else $error("ripple result wrong");

  AST_FIVE_UPPER: assert property (!rippleMode && upperMode == LFU_FIVE_IN |-> tableF[3] == tableBits[32 + upperIn]) // R17
    else $error("upper five-input result wrong");

  AST_BYPASS0: assert property (bypass[0] |-> resultBus[0] == tableF[0]) // R06
    else $error("bypass path not combinational");

  AST_DIRECT_LOAD: assert property (seqLoadDirect0 ##1 seqQuiet |-> resultBus[0] == $past(directStoreBus[0])) // R05
    else $error("direct bus not loaded");

  AST_GATE_BLOCKS: assert property (strobeEdge && !gateActive && !asyncForce ##1 !asyncForce |-> $stable(storeQ)) // R08
    else $error("storage changed while gate blocked");

  AST_GLOBAL_RESET: assert property (!globalSetResetN |-> storeQ == setValue) // R10
    else $error("global set/reset not immediate");

  AST_SYNC_LSR: assert property (syncForce && !asyncForce ##1 !asyncForce |-> storeQ == $past(setValue)) // R09
    else $error("synchronous set/reset not applied");

  AST_READ_ONCE: assert property (regRead ##1 !regRead |=> regReadData == 32'h00000000)
    else $error("read data held beyond one cycle");

endmodule

//--- rtl/lfu_pkg.sv
// types shared by the logic cell function unit
package lfu_pkg;

  // ----------------------------------------------------------------
  // per-half table mode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LFU_DUAL_FOUR_IN = 2'b00,
    LFU_FIVE_IN = 2'b01,
    LFU_MEMORY = 2'b10
  } lfu_half_mode_t;

  // ----------------------------------------------------------------
  // special gate mode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LFU_SPECIAL_NONE = 2'b00,
    LFU_FIVE_IN_MUX_COMBO = 2'b01,
    LFU_FIVE_IN_XOR_COMBO = 2'b10
  } lfu_special_t;

endpackage

//--- rtl/lfu_regs.svh
// register offsets, field positions and reset values of the logic cell function unit
`ifndef LFU_REGS_SVH
`define LFU_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define LFU_ADDR_W 8
`define LFU_OFS_MODE 8'h00
`define LFU_OFS_CTRL 8'h04
`define LFU_OFS_TABLE_LO 8'h08
`define LFU_OFS_TABLE_HI 8'h0c
`define LFU_OFS_STATUS 8'h10

// ----------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------
`define LFU_MODE_UPPER_LSB 0
`define LFU_MODE_LOWER_LSB 2
`define LFU_MODE_RIPPLE_BIT 4
`define LFU_MODE_SPECIAL_LSB 5
`define LFU_MODE_W 7
`define LFU_MODE_RESET 7'h00

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define LFU_CTRL_STROBE_INV 0
`define LFU_CTRL_GATE_EN 1
`define LFU_CTRL_GATE_INV 2
`define LFU_CTRL_LSR_EN 3
`define LFU_CTRL_LSR_INV 4
`define LFU_CTRL_LSR_ASYNC 5
`define LFU_CTRL_SPECIAL_EN 6
`define LFU_CTRL_SPECIAL_INV 7
`define LFU_CTRL_DIRECT_LSB 8
`define LFU_CTRL_SETVAL_LSB 12
`define LFU_CTRL_BYPASS_LSB 16
`define LFU_CTRL_W 20
`define LFU_CTRL_RESET 20'h00000

// ----------------------------------------------------------------
// status register fields and table reset value
// ----------------------------------------------------------------
`define LFU_STAT_STORE_LSB 0
`define LFU_STAT_RESULT_LSB 4
`define LFU_STAT_CARRY_BIT 9
`define LFU_STAT_TABLE_LSB 10
`define LFU_TABLE_RESET 64'h0000000000000000

`endif

//--- rtl/lfu_store_cell.sv
// one storage element of the function unit
`timescale 1ns/1ps

module lfu_store_cell
  import lfu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dataIn,
  input wire logic capture,
  input wire logic syncForce,
  input wire logic asyncForce,
  input wire logic setValue,
  output logic q
);

  logic held;

  // ----------------------------------------------------------------
  // held state
  // ----------------------------------------------------------------

  // forced value is also loaded so it survives the release of the force
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      held <= 1'b0;
    end else if (asyncForce) begin
      held <= setValue; // R11
    end else if (syncForce) begin
      held <= setValue; // R09
    end else if (capture) begin
      held <= dataIn;
    end
  end

  // output override acts at once, without waiting for an edge
  assign q = asyncForce ? setValue : held; // R11

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_FORCE_HOLDS: assert property (asyncForce ##1 (!asyncForce && !syncForce && !capture) |-> q == $past(setValue)) // R11
    else $error("forced value not kept after force released");

endmodule
